// ---- rtl/dcr_top.sv ----
// Implementation choice: register access over Wishbone.
`include "dcr_regs.svh"
// Operation
// (RQ1) A 4-bit channel select field names the channel that every per-channel access hits.
// (RQ2) Software writes the channel select field before touching any per-channel register.
// (RQ3) Disabling a channel mid-transfer keeps enable set until the buffer drains, then aborts; in the code a disable on the last beat leaves enable set.
// (RQ4) A disable-induced abort first completes the burst already under way.
// (RQ5) Writing one to channel enable enables the channel, zero disables, zero reads disabled.
// (RQ6) Channel enable stays writable while the controller is enabled.
// (RQ7) Writing one to soft reset resets the selected channel's registers; zero does nothing.
// (RQ8) A soft reset write is ignored while the selected channel is enabled.
// (RQ9) The soft reset bit reads one while the reset runs and clears itself after.
// (RQ10) The 2-bit command field means no action, suspend, resume; three is reserved.
// (RQ11) Command and arbitration level fields are writable while the controller is enabled.
// (RQ12) Trigger action makes one trigger start a block, beat or transaction; one is reserved.
// (RQ13) The 6-bit trigger source picks a peripheral request, zero meaning none, up to 0x31.
// (RQ14) The 2-bit arbitration level orders service, higher levels first.
// (RQ15) The descriptor base address resets to zero and is writable only with the controller off.
// (RQ16) The write-back base address resets to zero and is writable only with the controller off.
// (RQ17) Per-channel reads return the selected channel's values, reserved bits reading zero.
module dcr_top
   import dcr_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [8:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic [31:0]                wb_dat_o,
   output logic                       wb_ack_o,
   // peripheral trigger requests
   input  wire logic [`DCR_NTRIG-1:0] periph_req_i,
   // system bus transfer side
   input  wire logic                  beat_ready_i,
   output logic                       xfer_req_o,
   output logic [3:0]                 xfer_ch_o,
   output logic [1:0]                 xfer_act_o,
   // configuration towards the fetch engine
   output logic [31:0]                desc_base_o,
   output logic [31:0]                wrb_base_o,
   output logic [`DCR_NCH-1:0]        ch_enable_o,
   output logic [`DCR_NCH-1:0]        ch_suspend_o
);
   // ==========================================
   // helpers
   function automatic logic ch_ok(input logic [3:0] c);
      return c <= `DCR_CH_LAST;
   endfunction

   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wr,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      for (int b = 0; b < 4; b++) begin
         r[b*8 +: 8] = sel[b] ? wr[b*8 +: 8] : old[b*8 +: 8];
      end
      return r;
   endfunction

   // ==========================================
   // state and submodules
   dcr_st_t             st;
   dcr_st_t             nx;
   dcr_mem_if           m ();
   logic [`DCR_NCH-1:0] arb_req;
   logic                arb_hold;
   logic                gnt_vld;
   logic [3:0]          gnt_ch;
   logic [5:0]          src;
   logic                trig_hit;
   logic [6:0]          idx;
   logic                wr_go;
   logic                in_xfer;
   logic                burst_end;
   logic [31:0]         rd;
   logic [3:0]          c;

   dcr_cfg_mem u_mem (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .m     (m.mem)
   );

   // no new grant while a bus write may change a channel
   assign arb_hold = (st.bus == DCR_BUS_EXEC) && wb_we_i;
   assign arb_req  = arb_hold ? '0 : (st.pend & st.ch_en & ~st.susp & ~st.abort);

   dcr_arb u_arb (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .req_i       (arb_req),
      .lvl_i       (st.lvl),
      .grant_vld_o (gnt_vld),
      .grant_ch_o  (gnt_ch)
   );

   // ==========================================
   // trigger source match for the scanned channel
   assign src      = m.rdata_b;
   assign trig_hit = (src != `DCR_SRC_NONE) && (src <= `DCR_SRC_MAX) // [RQ13]
                     && periph_req_i[6'(src - 6'h01)];

   assign idx     = wb_adr_i[8:2];
   assign c       = st.chsel;
   assign wr_go   = (st.bus == DCR_BUS_EXEC) && wb_we_i;
   assign in_xfer = (st.xs == DCR_XF_BURST) && (st.xch == st.chsel);

   // ==========================================
   // next state
   always_comb begin
      nx        = st;
      burst_end = 1'b0;
      rd        = 32'h0000_0000;
      m.we      = 1'b0;
      m.waddr   = st.chsel;
      m.wdata   = `DCR_SRC_NONE;
      m.raddr_a = st.chsel; // [RQ1]
      m.raddr_b = st.scan;

      // round scan of trigger sources
      nx.scan   = (st.scan == `DCR_CH_LAST) ? 4'h0 : st.scan + 4'h1;
      nx.scan_d = st.scan;

      // transfer engine
      unique case (st.xs)
         DCR_XF_IDLE: begin
            if (gnt_vld) begin
               nx.xs           = DCR_XF_BURST;
               nx.xch          = gnt_ch;
               nx.xact         = st.trigger_action[gnt_ch];
               nx.beats        = 3'h0;
               nx.pend[gnt_ch] = 1'b0;
            end
         end
         DCR_XF_BURST: begin
            if (beat_ready_i) begin
               if (st.xact == DCR_TA_BEAT || st.beats == `DCR_BURST_LAST) begin // [RQ12]
                  burst_end = 1'b1;
               end else begin
                  nx.beats = st.beats + 3'h1;
               end
            end
         end
      endcase
      if (burst_end) begin
         nx.xs = DCR_XF_IDLE;
         // drained buffer ends a pending disable
         if (st.abort[st.xch]) begin
            nx.ch_en[st.xch] = 1'b0; // [RQ3] [RQ4]
            nx.abort[st.xch] = 1'b0;
            nx.pend[st.xch]  = 1'b0;
         end
      end

      // read word of the addressed register
      unique case (idx)
         `DCR_IDX_CTRL:  rd[`DCR_CTRL_EN] = st.ctrl_en;
         `DCR_IDX_STAT: begin
            rd[`DCR_NCH-1:0]   = st.ch_en;
            rd[`DCR_STAT_BUSY] = (st.xs == DCR_XF_BURST);
         end
         `DCR_IDX_DESC:  rd = st.desc_base;
         `DCR_IDX_WRB:   rd = st.wrb_base;
         `DCR_IDX_CHSEL: rd[3:0] = st.chsel;
         `DCR_IDX_CHP: begin
            if (ch_ok(c)) begin
               rd[`DCR_CHP_EN]   = st.ch_en[c]; // [RQ17]
               rd[`DCR_CHP_SRST] = st.srst_on && (st.srst_ch == c); // [RQ9]
            end
         end
         `DCR_IDX_CHS: begin
            if (ch_ok(c)) begin
               rd[`DCR_TA_LSB +: 2]  = st.trigger_action[c]; // [RQ17]
               rd[`DCR_SRC_LSB +: 6] = m.rdata_a;
               rd[`DCR_LVL_LSB +: 2] = st.lvl[c];
            end
         end
         default: rd = 32'h0000_0000;
      endcase

      // bus slave sequence
      unique case (st.bus)
         DCR_BUS_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               nx.bus = DCR_BUS_EXEC;
            end
         end
         DCR_BUS_EXEC: begin
            nx.bus = DCR_BUS_ACK;
            nx.ack = 1'b1;
            nx.dat = wb_we_i ? 32'h0000_0000 : rd;
         end
         DCR_BUS_ACK: begin
            nx.bus = DCR_BUS_IDLE;
            nx.ack = 1'b0;
         end
      endcase

      // register writes
      if (wr_go) begin
         unique case (idx)
            `DCR_IDX_CTRL: begin
               if (wb_sel_i[0]) begin
                  nx.ctrl_en = wb_dat_i[`DCR_CTRL_EN];
               end
            end
            `DCR_IDX_DESC: begin
               if (!st.ctrl_en) begin
                  nx.desc_base = lane_merge(st.desc_base, wb_dat_i, wb_sel_i); // [RQ15]
               end
            end
            `DCR_IDX_WRB: begin
               if (!st.ctrl_en) begin
                  nx.wrb_base = lane_merge(st.wrb_base, wb_dat_i, wb_sel_i); // [RQ16]
               end
            end
            `DCR_IDX_CHSEL: begin
               if (wb_sel_i[0]) begin
                  nx.chsel = wb_dat_i[3:0]; // [RQ1]
               end
            end
            `DCR_IDX_CHP: begin
               if (wb_sel_i[0] && ch_ok(c)) begin
                  if (wb_dat_i[`DCR_CHP_EN]) begin
                     nx.ch_en[c] = 1'b1; // [RQ5] [RQ6]
                     nx.abort[c] = 1'b0;
                  end else if (in_xfer) begin
                     nx.abort[c] = 1'b1; // [RQ3]
                  end else begin
                     nx.ch_en[c] = 1'b0; // [RQ5]
                     nx.pend[c]  = 1'b0;
                  end
                  if (wb_dat_i[`DCR_CHP_SRST] && !st.ch_en[c]) begin // [RQ7] [RQ8]
                     nx.srst_on  = 1'b1;
                     nx.srst_ch  = c;
                     nx.ch_en[c] = 1'b0;
                  end
               end
            end
            `DCR_IDX_CHS: begin
               if (ch_ok(c)) begin
                  if (wb_sel_i[3]) begin
                     unique case (wb_dat_i[`DCR_CMD_LSB +: 2]) // [RQ10] [RQ11]
                        DCR_CMD_SUSPEND: nx.susp[c] = 1'b1;
                        DCR_CMD_RESUME:  nx.susp[c] = 1'b0;
                        default:         nx.susp[c] = st.susp[c];
                     endcase
                  end
                  if (wb_sel_i[0]) begin
                     nx.lvl[c] = wb_dat_i[`DCR_LVL_LSB +: 2]; // [RQ11] [RQ14]
                  end
                  if (!st.ctrl_en) begin
                     if (wb_sel_i[2] && wb_dat_i[`DCR_TA_LSB +: 2] != `DCR_TA_RSVD) begin
                        nx.trigger_action[c] = wb_dat_i[`DCR_TA_LSB +: 2]; // [RQ12]
                     end
                     if (wb_sel_i[1]) begin
                        m.we    = 1'b1; // [RQ13]
                        m.waddr = c;
                        m.wdata = wb_dat_i[`DCR_SRC_LSB +: 6];
                     end
                  end
               end
            end
            default: nx.ctrl_en = st.ctrl_en;
         endcase
      end

      // soft reset of one channel takes one cycle
      if (st.srst_on) begin
         m.we                 = 1'b1; // [RQ7] [RQ9]
         m.waddr              = st.srst_ch;
         m.wdata              = `DCR_SRC_NONE;
         nx.lvl[st.srst_ch]   = 2'h0;
         nx.trigger_action[st.srst_ch] = 2'h0;
         nx.susp[st.srst_ch]  = 1'b0;
         nx.pend[st.srst_ch]  = 1'b0;
         nx.abort[st.srst_ch] = 1'b0;
         nx.srst_on           = 1'b0;
      end

      // a new trigger on an enabled, non-aborting channel wins over the grant clear in the same cycle
      if (trig_hit && nx.ch_en[st.scan_d] && !nx.abort[st.scan_d]) begin
         nx.pend[st.scan_d] = 1'b1; // [RQ13]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st           <= '0;
         st.desc_base <= `DCR_BASE_RST;
         st.wrb_base  <= `DCR_BASE_RST;
         st.chsel     <= `DCR_CHSEL_RST;
      end else begin
         st <= nx;
      end
   end

   // ==========================================
   // outputs
   assign wb_ack_o     = st.ack;
   assign wb_dat_o     = st.dat;
   assign xfer_req_o   = (st.xs == DCR_XF_BURST);
   assign xfer_ch_o    = st.xch;
   assign xfer_act_o   = st.xact;
   assign desc_base_o  = st.desc_base;
   assign wrb_base_o   = st.wrb_base;
   assign ch_enable_o  = st.ch_en;
   assign ch_suspend_o = st.susp;

   // ==========================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_chp_wr;
      wr_go && idx == `DCR_IDX_CHP && wb_sel_i[0] && ch_ok(c);
   endsequence

   a_sel_read_path: assert property ( // [RQ1]
      st.bus == DCR_BUS_EXEC && !wb_we_i && idx == `DCR_IDX_CHS && ch_ok(c)
      |=> wb_ack_o && wb_dat_o[`DCR_SRC_LSB +: 6] == $past(m.rdata_a)
          && wb_dat_o[31:26] == 6'h00)
      else $error("per-channel read not from selected channel");
   a_abort_hold: assert property ( // [RQ3]
      st.xs == DCR_XF_BURST && st.abort[st.xch] && !beat_ready_i
      |=> st.ch_en[$past(st.xch)])
      else $error("enable dropped before burst drained");
   a_abort_finish: assert property ( // [RQ4]
      burst_end && st.abort[st.xch]
      |=> !st.ch_en[$past(st.xch)] && st.xs == DCR_XF_IDLE)
      else $error("abort not completed at burst end");
   a_enable_write: assert property ( // [RQ5]
      s_chp_wr ##0 wb_dat_i[`DCR_CHP_EN] && !(wb_dat_i[`DCR_CHP_SRST] && !st.ch_en[c])
      |=> st.ch_en[$past(c)] && wb_ack_o)
      else $error("channel enable write lost");
   a_disable_idle: assert property ( // [RQ5]
      s_chp_wr ##0 !wb_dat_i[`DCR_CHP_EN] && !in_xfer |=> !st.ch_en[$past(c)])
      else $error("idle channel not disabled");
   a_srst_ignored: assert property ( // [RQ8]
      s_chp_wr ##0 wb_dat_i[`DCR_CHP_SRST] && st.ch_en[c] && !st.srst_on |=> !st.srst_on)
      else $error("soft reset taken on enabled channel");
   a_srst_clears: assert property ( // [RQ9]
      st.srst_on |=> !st.srst_on && st.lvl[$past(st.srst_ch)] == 2'h0
                     && st.trigger_action[$past(st.srst_ch)] == 2'h0 ##1 m.rdata_b == 6'h00
                     || $past(m.raddr_b) != $past(st.srst_ch, 2))
      else $error("soft reset did not finish in one cycle");
   a_base_locked: assert property ( // [RQ15]
      (st.ctrl_en && st.bus != DCR_BUS_EXEC) [*2]
      |-> $stable(st.desc_base) && $stable(st.wrb_base))
      else $error("base address changed while controller enabled");
   a_suspend_cmd: assert property ( // [RQ10]
      wr_go && idx == `DCR_IDX_CHS && wb_sel_i[3] && ch_ok(c) && !st.srst_on
      && wb_dat_i[`DCR_CMD_LSB +: 2] == DCR_CMD_SUSPEND |=> st.susp[$past(c)])
      else $error("suspend command not executed");
   a_level_open: assert property ( // [RQ11]
      wr_go && idx == `DCR_IDX_CHS && wb_sel_i[0] && ch_ok(c) && st.ctrl_en
      |=> st.lvl[$past(c)] == $past(wb_dat_i[`DCR_LVL_LSB +: 2]))
      else $error("level write refused while enabled");
   a_beat_single: assert property ( // [RQ12]
      st.xs == DCR_XF_BURST && st.xact == DCR_TA_BEAT && beat_ready_i
      |=> st.xs == DCR_XF_IDLE)
      else $error("beat action moved more than one beat");

   c_abort_seen:  cover property (burst_end && st.abort[st.xch]);
   c_srst_run:    cover property (st.srst_on);
   c_trig_grant:  cover property (trig_hit ##[1:30] gnt_vld);
   c_prot_refuse: cover property (wr_go && idx == `DCR_IDX_DESC && st.ctrl_en);
endmodule

// ---- rtl/dcr_regs.svh ----
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH
// ==========================================
// channel count and trigger lines
`define DCR_NCH         12
`define DCR_CH_LAST     4'hB
`define DCR_NTRIG       49
// ==========================================
// register indices, byte address is four times the index
`define DCR_IDX_CTRL    7'h00
`define DCR_IDX_STAT    7'h01
`define DCR_IDX_DESC    7'h34
`define DCR_IDX_WRB     7'h38
`define DCR_IDX_CHSEL   7'h3F
`define DCR_IDX_CHP     7'h40
`define DCR_IDX_CHS     7'h44
// ==========================================
// field positions
`define DCR_CTRL_EN     1
`define DCR_STAT_BUSY   16
`define DCR_CHP_EN      1
`define DCR_CHP_SRST    0
`define DCR_CMD_LSB     24
`define DCR_TA_LSB      22
`define DCR_SRC_LSB     8
`define DCR_LVL_LSB     5
// ==========================================
// reset values and codes
`define DCR_BASE_RST    32'h0000_0000
`define DCR_CHSEL_RST   4'h0
`define DCR_SRC_NONE    6'h00
`define DCR_SRC_MAX     6'h31
`define DCR_TA_RSVD     2'h1
// ==========================================
// timing counts
`define DCR_BURST_LAST  3'h3
`endif

// ---- rtl/dcr_pkg.sv ----
`include "dcr_regs.svh"
package dcr_pkg;
   typedef enum logic [1:0] {
      DCR_CMD_NO_ACTION   = 2'h0,
      DCR_CMD_SUSPEND = 2'h1,
      DCR_CMD_RESUME  = 2'h2
   } dcr_cmd_t;
   typedef enum logic [1:0] {
      DCR_TA_BLOCK       = 2'h0,
      DCR_TA_BEAT        = 2'h2,
      DCR_TA_TRANSACTION = 2'h3
   } dcr_trigger_action_t;
   typedef enum logic [1:0] {DCR_BUS_IDLE, DCR_BUS_EXEC, DCR_BUS_ACK} dcr_bus_t;
   typedef enum logic {DCR_XF_IDLE, DCR_XF_BURST} dcr_xfer_t;
   typedef logic [`DCR_NCH-1:0][1:0] dcr_lvl_vec_t;
   typedef struct packed {
      dcr_bus_t                 bus;
      logic                     ack;
      logic [31:0]              dat;
      logic                     ctrl_en;
      logic [31:0]              desc_base;
      logic [31:0]              wrb_base;
      logic [3:0]               chsel;
      logic [`DCR_NCH-1:0]      ch_en;
      logic [`DCR_NCH-1:0]      susp;
      logic [`DCR_NCH-1:0]      pend;
      logic [`DCR_NCH-1:0]      abort;
      dcr_lvl_vec_t             lvl;
      dcr_lvl_vec_t             trigger_action;
      logic                     srst_on;
      logic [3:0]               srst_ch;
      logic [3:0]               scan;
      logic [3:0]               scan_d;
      dcr_xfer_t                xs;
      logic [3:0]               xch;
      logic [1:0]               xact;
      logic [2:0]               beats;
   } dcr_st_t;
   typedef struct packed {
      logic [`DCR_NCH-1:0][5:0] src;
      logic [5:0]               rd_a;
      logic [5:0]               rd_b;
   } dcr_mem_st_t;
endpackage

// ---- rtl/dcr_mem_if.sv ----
interface dcr_mem_if;
   logic       we;
   logic [3:0] waddr;
   logic [5:0] wdata;
   logic [3:0] raddr_a;
   logic [3:0] raddr_b;
   logic [5:0] rdata_a;
   logic [5:0] rdata_b;
   modport ctrl (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
   modport mem  (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface

// ---- rtl/dcr_cfg_mem.sv ----
`include "dcr_regs.svh"
module dcr_cfg_mem
   import dcr_pkg::*;
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // storage port
   dcr_mem_if.mem    m
);
   dcr_mem_st_t st;
   dcr_mem_st_t nx;

   always_comb begin
      nx = st;
      if (m.we && m.waddr <= `DCR_CH_LAST) begin
         nx.src[m.waddr] = m.wdata;
      end
      nx.rd_a = (m.raddr_a <= `DCR_CH_LAST) ? st.src[m.raddr_a] : `DCR_SRC_NONE;
      nx.rd_b = (m.raddr_b <= `DCR_CH_LAST) ? st.src[m.raddr_b] : `DCR_SRC_NONE;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign m.rdata_a = st.rd_a;
   assign m.rdata_b = st.rd_b;

   a_write_readback: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ13]
      m.we ##1 (m.raddr_a == $past(m.waddr) && !m.we) |=> m.rdata_a == $past(m.wdata, 2))
      else $error("stored trigger source not read back");
endmodule

// ---- rtl/dcr_arb.sv ----
`include "dcr_regs.svh"
module dcr_arb
   import dcr_pkg::*;
(
   // clock and reset, checks only
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // requests
   input  wire logic [`DCR_NCH-1:0] req_i,
   input  wire dcr_lvl_vec_t        lvl_i,
   // grant
   output logic                     grant_vld_o,
   output logic [3:0]               grant_ch_o
);
   logic [1:0]          best;
   logic [`DCR_NCH-1:0] higher;

   // highest level first, lowest channel wins a tie
   always_comb begin
      grant_vld_o = 1'b0;
      grant_ch_o  = 4'h0;
      best        = 2'h0;
      for (int i = 0; i < `DCR_NCH; i++) begin
         if (req_i[i] && (!grant_vld_o || lvl_i[i] > best)) begin // [RQ14]
            grant_vld_o = 1'b1;
            grant_ch_o  = 4'(i);
            best        = lvl_i[i];
         end
      end
   end

   for (genvar g = 0; g < `DCR_NCH; g++) begin : g_hi
      assign higher[g] = req_i[g] && (lvl_i[g] > lvl_i[grant_ch_o]);
   end

   a_level_first: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ14]
      grant_vld_o |-> higher == '0 && req_i[grant_ch_o])
      else $error("lower level granted over a higher one");
endmodule

// ---- verif/dcr_peer.sv ----
`include "dcr_regs.svh"
// ==========================================
// trigger sources and system bus beat acceptor
module dcr_peer (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // bench control
   input  wire logic [`DCR_NTRIG-1:0] want_i,
   input  wire logic                  stall_i,
   // device side
   input  wire logic                  xfer_req_i,
   output logic [`DCR_NTRIG-1:0]      periph_req_o,
   output logic                       beat_ready_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] lfsr_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_req_o <= '0;
         lfsr_reg     <= 16'hACE1;
      end else begin
         periph_req_o <= want_i;
         lfsr_reg     <= {lfsr_reg[14:0],
                          lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      end
   end
   // beats accepted only within a burst, with random wait cycles
   assign beat_ready_o = xfer_req_i & ~stall_i & lfsr_reg[0];
endmodule

// ---- verif/testbench.sv ----
`include "dcr_regs.svh"
module testbench
   import dcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [8:0] A_CTL = 9'h000, A_DSC = 9'h0D0, A_WRB = 9'h0E0;
   localparam logic [8:0] A_SEL = 9'h0FC, A_PRI = 9'h100, A_SEC = 9'h110;
   logic                  clk_i = 0, rst_i = 1;
   logic                  cyc = 0, stb = 0, we = 0, stall = 0, xreq, rdy, ack;
   logic [8:0]            adr = '0;
   logic [3:0]            sel = '0, xch;
   logic [1:0]            xact;
   logic [31:0]           wd = '0, rd, q, r, dsc = '0, dbo, wbo;
   logic [`DCR_NTRIG-1:0] want = '0, preq;
   logic [`DCR_NCH-1:0]   ch_en, ch_su;
   logic [31:0]           exp_sec [`DCR_NCH];
   logic [31:0]           seed = 32'h0000_000B;
   int                    fails = 0, n_tests = 0;
   always #10 clk_i = ~clk_i;
   dcr_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
      .periph_req_i(preq), .beat_ready_i(rdy), .xfer_req_o(xreq), .xfer_ch_o(xch),
      .xfer_act_o(xact), .desc_base_o(dbo), .wrb_base_o(wbo), .ch_enable_o(ch_en),
      .ch_suspend_o(ch_su));
   dcr_peer peer (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .stall_i(stall),
      .xfer_req_i(xreq), .periph_req_o(preq), .beat_ready_o(rdy));
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] s);
      for (int i = 0; i < 4; i++) if (s[i]) o[8*i+:8] = n[8*i+:8];
      return o;
   endfunction
   // stored view of a secondary write: command reads zero, reserved bits zero
   function logic [31:0] sec(input logic [31:0] w);
      return {8'h00, w[23:22], 8'h00, w[13:8], 1'b0, w[6:5], 5'h00};
   endfunction
   task summarize();
      if (fails == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, sel, wd} <= {2'b11, w, a, s, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 40);
      if (n >= 40) fails++;
      q = rd;
      {cyc, stb, we} <= 3'b000;
   endtask
   task rdc(input logic [8:0] a, input logic [31:0] e);
      bus(0, a, 32'h0, 4'hF);
      chk(q, e);
   endtask
   task pick(input int c);
      bus(1, A_SEL, 32'(c), 4'hF);
   endtask
   task cfg(input int c, input logic [1:0] ta, input logic [5:0] src, input logic [1:0] lv);
      pick(c);
      exp_sec[c] = {8'h00, ta, 8'h00, src, 1'b0, lv, 5'h00};
      // resume too, an earlier random command may have suspended it
      bus(1, A_SEC, exp_sec[c] | 32'h0200_0000, 4'hF);
   endtask
   task wait_req(input logic v);
      int n;
      n = 0;
      while (xreq !== v && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 400) fails++;
   endtask
   initial begin
      #800_000;
      fails++;
      summarize();
   end
   initial begin
      logic [1:0] ta_tab [3];
      logic [1:0] cmds [4];
      logic       susp [4];
      ta_tab = '{DCR_TA_BLOCK, DCR_TA_BEAT, DCR_TA_TRANSACTION};
      cmds = '{DCR_CMD_SUSPEND, 2'h3, DCR_CMD_NO_ACTION, DCR_CMD_RESUME};
      susp = '{1'b1, 1'b1, 1'b1, 1'b0};
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      rdc(A_DSC, 32'h0);
      rdc(A_WRB, 32'h0);
      rdc(A_SEL, 32'h0);
      rdc(A_SEC, 32'h0);
      rdc(A_PRI, 32'h0);
      for (int k = 0; k < 4; k++) begin
         r = xs();
         bus(1, A_DSC, r, seed[3:0]);
         dsc = merge(dsc, r, seed[3:0]);
         rdc(A_DSC, dsc);
         bus(1, A_WRB, ~r, 4'hF);
         rdc(A_WRB, ~r);
         chk(wbo, ~r);
      end
      for (int c = 0; c < `DCR_NCH; c++) begin
         pick(c);
         r = xs();
         r[23:22] = ta_tab[r[31:24] % 3];
         r[13:8] = (c == 11) ? `DCR_SRC_MAX : 6'(r[13:8] % 50);
         bus(1, A_SEC, r, 4'hF);
         exp_sec[c] = sec(r);
      end
      for (int c = 0; c < `DCR_NCH; c++) begin
         pick(c);
         rdc(A_SEC, exp_sec[c]);
      end
      bus(1, A_SEC, 32'h0040_0000, 4'h4);
      rdc(A_SEC, exp_sec[11]);
      for (int k = 0; k < 4; k++) begin
         bus(1, A_SEC, {6'h00, cmds[k], 24'h0}, 4'h8);
         @(negedge clk_i);
         chk(32'(ch_su[11]), 32'(susp[k]));
      end
      rdc(A_SEC, exp_sec[11]);
      pick(3);
      bus(1, A_PRI, 32'h2, 4'h1);
      rdc(A_PRI, 32'h2);
      bus(1, A_PRI, 32'h3, 4'h1);
      rdc(A_SEC, exp_sec[3]);
      bus(1, A_PRI, 32'h0, 4'h1);
      rdc(A_PRI, 32'h0);
      bus(1, A_PRI, 32'h1, 4'h1);
      rdc(A_PRI, 32'h0);
      rdc(A_SEC, 32'h0);
      cfg(0, DCR_TA_BEAT, 6'h01, 2'h1);
      cfg(2, DCR_TA_BLOCK, 6'h03, 2'h0);
      cfg(5, DCR_TA_TRANSACTION, `DCR_SRC_MAX, 2'h3);
      bus(1, A_CTL, 32'h2, 4'h1);
      bus(1, A_DSC, ~dsc, 4'hF);
      rdc(A_DSC, dsc);
      chk(dbo, dsc);
      pick(9);
      r = xs();
      bus(1, A_SEC, r & 32'h00FF_FFFF, 4'hF);
      rdc(A_SEC, {exp_sec[9][31:7], r[6:5], 5'h00});
      foreach (ta_tab[i]) begin
         pick((i * i + 3 * i) / 2);
         bus(1, A_PRI, 32'h2, 4'h1);
      end
      chk(32'(ch_en), 32'h025);
      rdc(9'h004, 32'h0000_0025);
      stall <= 1;
      want[0] <= 1;
      wait_req(1);
      chk({xch, xact}, {4'h0, DCR_TA_BEAT});
      {want[48], want[2], want[0]} <= 3'b110;
      repeat (30) @(posedge clk_i);
      pick(0);
      bus(1, A_PRI, 32'h0, 4'h1);
      chk({xreq, ch_en[0]}, 2'b11);
      stall <= 0;
      wait_req(0);
      repeat (2) @(posedge clk_i);
      chk(32'(ch_en[0]), 32'h0);
      wait_req(1);
      chk({xch, xact}, {4'h5, DCR_TA_TRANSACTION});
      wait_req(0);
      summarize();
   end
endmodule
